// file: common/gpio_spi_pkg.sv
// Package: constants for the six-pin port with SPI master
package gpio_spi_pkg;
   localparam int unsigned NUM_PINS     = 6;
   // Pin indices (zero based) for the SPI takeover of pins 2..5
   localparam int unsigned PIN_SS       = 2;
   localparam int unsigned PIN_MOSI     = 3;
   localparam int unsigned PIN_MISO     = 4;
   localparam int unsigned PIN_SCLK     = 5;
   // Pull select encodings
   localparam logic [2:0]  PULL_ADC     = 3'h0;
   localparam logic [2:0]  PULL_PUSH    = 3'h1;
   localparam logic [2:0]  PULL_UP      = 3'h2;
   localparam logic [2:0]  PULL_DOWN    = 3'h3;
   // Fault enable encodings
   localparam logic [1:0]  FLT_OFF      = 2'h0;
   localparam logic [1:0]  FLT_LOW      = 2'h1;
   localparam logic [1:0]  FLT_HIGH     = 2'h2;
   // Serial clock half period in ns, and in core cycles rounded up
   localparam int unsigned SCLK_HALF_NS = 80;
   localparam int unsigned CLK_NS       = 5;
   localparam int unsigned HALF_CYCLES  = (SCLK_HALF_NS + CLK_NS - 1) / CLK_NS;
   localparam logic [7:0]  RESET_BYTE   = 8'h00;
   typedef enum logic [2:0] {
      ST_IDLE  = 3'b001,
      ST_LEAD  = 3'b010,
      ST_TRAIL = 3'b100
   } spi_state_t;
endpackage : gpio_spi_pkg

// file: hdl/gpio_spi_master_port.sv
// Design: six general-purpose pins with SPI master takeover
`timescale 1ns/100ps
module gpio_spi_master_port #(
   parameter int unsigned HALF = gpio_spi_pkg::HALF_CYCLES
) (
   input  wire logic        clk,
   input  wire logic        reset,
   // Per-pin configuration
   input  wire logic [5:0]  pin_is_output,
   input  wire logic [17:0] pull_select,
   input  wire logic [11:0] pin_fault_enable_field,
   input  wire logic [5:0]  addr_select,
   input  wire logic [5:0]  pin_out_level,
   input  wire logic [5:0]  fault_clear,
   // SPI configuration
   input  wire logic        spi_enable,
   input  wire logic        ss_level,
   input  wire logic [2:0]  transfer_length,
   input  wire logic        cpol,
   input  wire logic        cpha,
   input  wire logic [7:0]  tx_data,
   input  wire logic        serial_execute_reg,
   input  wire logic        diagnostic_control,
   // Pins
   input  wire logic [5:0]  pin_in,
   output logic      [5:0]  pin_out,
   output logic      [5:0]  pin_oe,
   output logic      [5:0]  pull_up_en,
   output logic      [5:0]  pull_down_en,
   output logic      [5:0]  adc_select,
   // Status
   output logic      [5:0]  pin_status,
   output logic      [5:0]  pin_fault,
   output logic      [7:0]  rx_data,
   output logic             spi_busy
);
   // ==========================================================
   // Pin input synchroniser
   logic [5:0] sync1_q;
   logic [5:0] sync2_q;
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         sync1_q <= 6'h00;
         sync2_q <= 6'h00;
      end else begin
         sync1_q <= pin_in;
         sync2_q <= sync1_q;
      end
   end

   // ==========================================================
   // SPI engine
   gpio_spi_pkg::spi_state_t state_q;
   logic [7:0]  tx_sh_q;
   logic [7:0]  rx_sh_q;
   logic [2:0]  len_q;
   logic [2:0]  bit_q;
   logic [7:0]  div_q;
   logic        sclk_q;
   logic        mosi_q;
   logic        loop_q;
   logic        ss_latch_q;
   logic        go_q;
   logic        half_done;
   logic        miso_bit;
   logic        go_rise;
   logic        last_bit;

   assign half_done = (div_q == 8'(HALF - 1));
   assign go_rise   = serial_execute_reg & ~go_q;
   assign last_bit  = (bit_q == len_q);
   assign miso_bit  = loop_q ? mosi_q : sync2_q[gpio_spi_pkg::PIN_MISO];

   // ==========================================================
   // Go request edge detect
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         go_q <= 1'b0;
      end else begin
         go_q <= serial_execute_reg;
      end
   end

   // Loopback mode register
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         loop_q <= 1'b0;
      end else begin
         loop_q <= diagnostic_control;
      end
   end

   // Loopback entry latches slave select
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         ss_latch_q <= 1'b1;
      end else if (diagnostic_control && !loop_q) begin
         ss_latch_q <= ss_level;
      end
   end

   // ==========================================================
   // Transfer state machine
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         state_q <= gpio_spi_pkg::ST_IDLE;
         tx_sh_q <= gpio_spi_pkg::RESET_BYTE;
         rx_sh_q <= gpio_spi_pkg::RESET_BYTE;
         rx_data <= gpio_spi_pkg::RESET_BYTE;
         len_q   <= 3'h0;
         bit_q   <= 3'h0;
         div_q   <= 8'h00;
         sclk_q  <= 1'b0;
         mosi_q  <= 1'b0;
      end else begin
         case (state_q)
            gpio_spi_pkg::ST_IDLE: begin
               sclk_q <= cpol;
               div_q  <= 8'h00;
               if (go_rise && spi_enable) begin
                  len_q   <= transfer_length;
                  bit_q   <= 3'h0;
                  tx_sh_q <= tx_data;
                  mosi_q  <= tx_data[0];
                  rx_sh_q <= rx_data;
                  state_q <= gpio_spi_pkg::ST_LEAD;
               end
            end
            gpio_spi_pkg::ST_LEAD: begin
               div_q <= half_done ? 8'h00 : div_q + 8'h01;
               if (half_done) begin
                  sclk_q <= ~cpol;
                  if (cpha) begin
                     mosi_q <= tx_sh_q[bit_q];
                  end else begin
                     rx_sh_q[bit_q] <= miso_bit;
                  end
                  state_q <= gpio_spi_pkg::ST_TRAIL;
               end
            end
            gpio_spi_pkg::ST_TRAIL: begin
               div_q <= half_done ? 8'h00 : div_q + 8'h01;
               if (half_done) begin
                  sclk_q <= cpol;
                  if (cpha) begin
                     rx_sh_q[bit_q] <= miso_bit;
                  end
                  if (last_bit) begin
                     state_q <= gpio_spi_pkg::ST_IDLE;
                     rx_data <= cpha ? {rx_sh_q[7:1], rx_sh_q[0]} : rx_sh_q;
                     if (cpha) begin
                        rx_data[bit_q] <= miso_bit;
                     end
                  end else begin
                     bit_q <= bit_q + 3'h1;
                     if (!cpha) begin
                        mosi_q <= tx_sh_q[bit_q + 3'h1];
                     end
                     state_q <= gpio_spi_pkg::ST_LEAD;
                  end
               end
            end
            default: begin
               state_q <= gpio_spi_pkg::ST_IDLE;
            end
         endcase
      end
   end

   // Busy flag
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         spi_busy <= 1'b0;
      end else begin
         spi_busy <= (state_q != gpio_spi_pkg::ST_IDLE) || (go_rise && spi_enable);
      end
   end

   // ==========================================================
   // Pin muxing, priority SPI > addressing > ADC > normal
   logic [5:0] out_d;
   logic [5:0] oe_d;
   logic [5:0] pu_d;
   logic [5:0] pd_d;
   logic [5:0] adc_d;
   logic [5:0] spi_pin;
   logic       spi_clk_pin;
   logic       spi_mosi_pin;
   logic       spi_ss_pin;

   // External pins stay still in loopback
   assign spi_clk_pin  = loop_q ? cpol : sclk_q;
   assign spi_mosi_pin = loop_q ? 1'b0 : mosi_q;
   assign spi_ss_pin   = loop_q ? ss_latch_q : ss_level;

   genvar g;
   generate
      for (g = 0; g < gpio_spi_pkg::NUM_PINS; g++) begin : g_pin
         logic [2:0] pull;
         logic [1:0] flt;
         assign pull       = pull_select[3*g +: 3];
         assign flt        = pin_fault_enable_field[2*g +: 2];
         assign spi_pin[g] = spi_enable && (g >= gpio_spi_pkg::PIN_SS);
         always_comb begin
            out_d[g] = 1'b0;
            oe_d[g]  = 1'b0;
            pu_d[g]  = 1'b0;
            pd_d[g]  = 1'b0;
            adc_d[g] = 1'b0;
            if (spi_pin[g]) begin
               oe_d[g] = (g != gpio_spi_pkg::PIN_MISO);
               if (g == gpio_spi_pkg::PIN_SS) begin
                  out_d[g] = spi_ss_pin;
               end else if (g == gpio_spi_pkg::PIN_MOSI) begin
                  out_d[g] = spi_mosi_pin;
               end else if (g == gpio_spi_pkg::PIN_SCLK) begin
                  out_d[g] = spi_clk_pin;
               end
            end else if (addr_select[g]) begin
               oe_d[g] = 1'b0;
            end else if (pull == gpio_spi_pkg::PULL_ADC) begin
               adc_d[g] = 1'b1;
            end else begin
               oe_d[g]  = pin_is_output[g];
               out_d[g] = pin_out_level[g];
               pu_d[g]  = (pull == gpio_spi_pkg::PULL_UP);
               pd_d[g]  = (pull == gpio_spi_pkg::PULL_DOWN);
            end
         end

         // Sticky fault flag, set wins over clear
         logic fault_hit;
         assign fault_hit = !spi_pin[g] && !addr_select[g] &&
                            (((flt == gpio_spi_pkg::FLT_HIGH) && sync2_q[g]) ||
                             ((flt == gpio_spi_pkg::FLT_LOW) && !sync2_q[g]));
         always_ff @(posedge clk or posedge reset) begin
            if (reset) begin
               pin_fault[g] <= 1'b0;
            end else if (fault_hit) begin
               pin_fault[g] <= 1'b1;
            end else if (fault_clear[g]) begin
               pin_fault[g] <= 1'b0;
            end
         end
      end
   endgenerate

   // ==========================================================
   // Registered pin outputs
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         pin_out <= 6'h00;
         pin_oe  <= 6'h00;
      end else begin
         pin_out <= out_d;
         pin_oe  <= oe_d;
      end
   end

   // Pull and ADC selects
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         pull_up_en   <= 6'h00;
         pull_down_en <= 6'h00;
         adc_select   <= 6'h00;
      end else begin
         pull_up_en   <= pu_d;
         pull_down_en <= pd_d;
         adc_select   <= adc_d;
      end
   end

   // Live level view
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         pin_status <= 6'h00;
      end else begin
         pin_status <= sync2_q;
      end
   end
endmodule : gpio_spi_master_port

// file: sim/spi_slave_model.sv
// Behavioural serial slave on the port pins
`timescale 1ns/100ps
module spi_slave_model (
   input  wire logic       sclk,
   input  wire logic       mosi,
   input  wire logic       ss_n,
   input  wire logic       smp_lvl,
   input  wire logic [7:0] resp,
   input  wire logic       restart,
   output logic            miso,
   output logic      [7:0] got
);
   // ==========
   // Shift logic
   logic [2:0] idx;
   logic       bit_q;
   always @(sclk or posedge restart) begin
      if (restart) begin
         idx = 3'h0;
         got = 8'h00;
         bit_q = resp[0];
      end else if (sclk === smp_lvl) begin
         got[idx] = mosi;
         idx = idx + 3'h1;
      end else begin
         bit_q = resp[idx];
      end
   end
   assign miso = ss_n ? ~bit_q : bit_q;
endmodule : spi_slave_model

// file: sim/gpio_spi_master_port_assertions.sv
// Concurrent checks on the port pins and serial master
`timescale 1ns/100ps
module gpio_spi_master_port_assertions (
   input wire logic        clk,
   input wire logic        reset,
   input wire logic [5:0]  pin_is_output,
   input wire logic [17:0] pull_select,
   input wire logic [5:0]  addr_select,
   input wire logic [5:0]  pin_out_level,
   input wire logic        spi_enable,
   input wire logic        ss_level,
   input wire logic        cpol,
   input wire logic        serial_execute_reg,
   input wire logic        diagnostic_control,
   input wire logic [5:0]  pin_out,
   input wire logic [5:0]  pin_oe,
   input wire logic [5:0]  adc_select,
   input wire logic [7:0]  rx_data,
   input wire logic        spi_busy
);
   // ==========
   // Properties
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);
   sclk_idle_a: assert property (spi_enable && $past(spi_enable) && !spi_busy && !$past(spi_busy)
      && !$past(reset) && $stable(cpol) && $past(cpol, 2) == cpol |-> pin_out[5] == cpol)
      else $error("clock not idle");
   go_taken_a: assert property ($rose(serial_execute_reg) && spi_enable && !spi_busy |-> ##[1:2] spi_busy)
      else $error("go not taken");
   go_refused_a: assert property ($rose(serial_execute_reg) && !spi_enable && !spi_busy |=> !spi_busy [*2])
      else $error("go taken while off");
   rx_hold_a: assert property ($changed(rx_data) |=> !spi_busy) else $error("rx moved");
   loop_quiet_a: assert property (diagnostic_control && $past(diagnostic_control, 2) && spi_enable
      && $past(spi_enable) && $past(spi_enable, 2) && $stable(cpol) |-> pin_out[5] == cpol && !pin_out[3])
      else $error("pins moved");
   ss_latch_a: assert property (diagnostic_control && $past(diagnostic_control)
      && $past(diagnostic_control, 2) && spi_enable && $past(spi_enable) && $past(spi_enable, 2)
      |-> $stable(pin_out[2])) else $error("select moved");
   ss_drive_a: assert property (spi_enable && $past(spi_enable) && !diagnostic_control
      && !$past(diagnostic_control) && !$past(diagnostic_control, 2) && !$past(reset)
      |-> pin_out[2] == $past(ss_level) && pin_oe[5:2] == 4'hb) else $error("bad pins");
   addr_input_a: assert property ($past(addr_select[0]) && !$past(reset) |-> !pin_oe[0] && !adc_select[0])
      else $error("address pin driven");
   out_level_a: assert property ($past(pin_is_output[0]) && !$past(addr_select[0])
      && $past(pull_select[2:0]) == 3'h1 && !$past(reset)
      |-> pin_oe[0] && pin_out[0] == $past(pin_out_level[0])) else $error("bad level");
   adc_use_a: assert property ($past(pull_select[2:0]) == 3'h0 && !$past(addr_select[0]) && !$past(reset)
      |-> adc_select[0]) else $error("adc not selected");
endmodule : gpio_spi_master_port_assertions
bind gpio_spi_master_port gpio_spi_master_port_assertions u_chk (.clk, .reset, .pin_is_output, .pull_select,
   .addr_select, .pin_out_level, .spi_enable, .ss_level, .cpol, .serial_execute_reg, .diagnostic_control,
   .pin_out, .pin_oe, .adc_select, .rx_data, .spi_busy);

// file: sim/tb.sv
// Self-checking bench for the six-pin port with serial master
`timescale 1ns/100ps
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin failures++; $display("Error %0t: %h not %h", $time, a, e); end end
module tb;
   // ==========
   // Signals
   logic        clk, reset, spi_enable, ss_level, cpol, cpha, serial_execute_reg, diagnostic_control;
   logic        restart, miso, spi_busy;
   logic [5:0]  pin_is_output, addr_select, pin_out_level, fault_clear, ext, w, pin_in, pin_out, pin_oe;
   logic [5:0]  pull_up_en, pull_down_en, adc_select, pin_status, pin_fault;
   logic [17:0] pull_select;
   logic [11:0] pin_fault_enable_field;
   logic [2:0]  transfer_length;
   logic [7:0]  tx_data, rx_data, resp, got;
   int          failures = 0;
   int          comparisons = 0;
   assign w = (pin_oe & pin_out) | (~pin_oe & ext);
   assign pin_in = {w[5], miso, w[3:0]};
   always #2.5 clk = ~clk;
   gpio_spi_master_port u_dut (.clk, .reset, .pin_is_output, .pull_select, .pin_fault_enable_field, .addr_select,
      .pin_out_level, .fault_clear, .spi_enable, .ss_level, .transfer_length, .cpol, .cpha, .tx_data,
      .serial_execute_reg, .diagnostic_control, .pin_in, .pin_out, .pin_oe, .pull_up_en, .pull_down_en,
      .adc_select, .pin_status, .pin_fault, .rx_data, .spi_busy);
   spi_slave_model u_slave (.sclk(pin_out[5]), .mosi(pin_out[3]), .ss_n(pin_out[2]), .smp_lvl(~(cpol ^ cpha)),
      .resp, .restart, .miso, .got);
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : tick
   task automatic report_and_stop();
      $display("Comparisons %0d mismatches %0d", comparisons, failures);
      if (failures == 0 && comparisons > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : report_and_stop
   task automatic wait_busy(input logic lvl);
      int k;
      k = 0;
      while (spi_busy !== lvl && k < 2000) begin
         tick(1);
         k++;
      end
      if (k == 2000) begin
         failures++;
         report_and_stop();
      end
   endtask : wait_busy
   task automatic xfer(input logic [1:0] md, input logic [2:0] len, input logic [7:0] tx, input logic [7:0] rsp);
      logic [7:0] m, exp;
      m = 8'hff >> (3'h7 - len);
      exp = (rx_data & ~m) | ((diagnostic_control ? tx : rsp) & m);
      {cpol, cpha} = md;
      transfer_length = len;
      tx_data = tx;
      resp = rsp;
      restart = 1'b1;
      tick(2);
      restart = 1'b0;
      serial_execute_reg = 1'b1;
      tick(1);
      serial_execute_reg = 1'b0;
      wait_busy(1'b1);
      tick(1);
      serial_execute_reg = 1'b1;
      tick(1);
      serial_execute_reg = 1'b0;
      wait_busy(1'b0);
      `CHK(rx_data, exp)
      if (!diagnostic_control) `CHK(got, tx & m)
      tick(3);
      `CHK(spi_busy, 1'b0)
   endtask : xfer
   // ==========
   // Sequence
   initial begin
      clk = 1'b0;
      reset = 1'b1;
      {pin_is_output, pull_select, pin_fault_enable_field, addr_select, pin_out_level, fault_clear, ext} = '0;
      {spi_enable, cpol, cpha, tx_data, serial_execute_reg, diagnostic_control, transfer_length, resp} = '0;
      restart = 1'b0;
      ss_level = 1'b1;
      tick(10);
      reset = 1'b0;
      tick(3);
      `CHK(adc_select, 6'h3f)
      pin_is_output = 6'h01;
      pin_out_level = 6'h01;
      pull_select = {12'h000, 3'h2, 3'h1};
      pin_fault_enable_field = 12'h008;
      ext = 6'h02;
      tick(6);
      `CHK({pin_oe[1:0], pin_out[0], pull_up_en[1]}, 4'h7)
      `CHK({pin_status[1:0], pin_fault[1:0]}, 4'he)
      ext = 6'h00;
      addr_select = 6'h01;
      tick(6);
      `CHK({pin_oe[0], pin_fault[1], pin_status[1]}, 3'h2)
      fault_clear = 6'h02;
      addr_select = 6'h00;
      pull_select = {12'h000, 3'h3, 3'h1};
      tick(3);
      `CHK(pin_fault[1], 1'b0)
      `CHK({pull_down_en[1], pull_up_en[1]}, 2'h2)
      fault_clear = 6'h00;
      $display("pin test done");
      spi_enable = 1'b1;
      ss_level = 1'b0;
      tick(3);
      `CHK({pin_oe[5:2], pin_out[2], adc_select[5:2]}, 9'h160)
      for (int i = 0; i < 4; i++) xfer(i[1:0], 3'(7 - 2 * i), 8'h3b + 8'(i), 8'hc5 ^ 8'(i));
      xfer(2'h0, 3'h0, 8'h01, 8'h01);
      $display("serial test done");
      diagnostic_control = 1'b1;
      tick(2);
      ss_level = 1'b1;
      tick(3);
      `CHK(pin_out[2], 1'b0)
      xfer(2'h0, 3'h7, 8'ha6, 8'h00);
      diagnostic_control = 1'b0;
      spi_enable = 1'b0;
      tick(2);
      serial_execute_reg = 1'b1;
      tick(2);
      `CHK(spi_busy, 1'b0)
      serial_execute_reg = 1'b0;
      $display("loopback test done");
      report_and_stop();
   end
endmodule : tb
